// ---- src/bus_path_consts.svh ----
// Constants for the bus request, frequency select and quad-pumped data path.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef BUS_PATH_CONSTS_SVH
`define BUS_PATH_CONSTS_SVH
`define DATA_W 64
`define GROUP_W 16
`define GROUPS 4
`define BEATS 4
`define BEAT_W 2
`define LAST_BEAT 2'h3
`define LINE_W 256
`define FIFO_DEPTH 4
`define FSEL_W 3
`define FSEL_CODE_A 3'h0
`define FSEL_CODE_B 3'h1
`define FSEL_CODE_C 3'h2
`define FSEL_CODE_D 3'h3
`define FSEL_DEFAULT 3'h0
`define RST_HOLD 2'h2
`endif

// ---- src/bus_path_pkg.sv ----
// Types shared by the bus path design.
package bus_path_pkg;
   // Transmit side link states, Gray coded along idle, request, drive, done.
   typedef enum logic [1:0] {
      tx_idle = 2'b00,
      tx_req = 2'b01,
      tx_drive = 2'b11,
      tx_done = 2'b10
   } tx_state_t;
endpackage

// ---- src/line_fifo.sv ----
// Small synchronous FIFO holding whole lines awaiting transmission.
`timescale 1ns/1ns
module line_fifo #(
   parameter int WIDTH = 256,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_q];
   assign out_valid = (cnt_q != '0);

   // Storage is written only on an accepted push.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // Pointers wrap at the depth; count and ready follow push and pop.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
            in_ready <= (cnt_q + 1'b1) != FULL;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
            in_ready <= 1'b1;
         end else begin
            in_ready <= cnt_q != FULL;
         end
      end
   end
endmodule // line_fifo

// ---- src/processor_bus_path.sv ----
// Processor side bus request, frequency select and quad-pumped data path.
`timescale 1ns/1ns
`include "bus_path_consts.svh"
module processor_bus_path
   import bus_path_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic beat_clk,
   input wire logic [`FSEL_W-1:0] freq_strap,
   output logic [`FSEL_W-1:0] bus_frequency_select,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [`LINE_W-1:0] tx_data,
   output logic rx_valid,
   output logic [`LINE_W-1:0] rx_data,
   input wire logic bus_ownership_request_n_in,
   output logic bus_ownership_request_n_out,
   output logic bus_ownership_request_n_oe,
   input wire logic priority_agent_request_n,
   input wire logic transfer_valid_indicator_n_in,
   output logic transfer_valid_indicator_n_out,
   output logic transfer_valid_indicator_n_oe,
   input wire logic [`DATA_W-1:0] bus_data_n_in,
   output logic [`DATA_W-1:0] bus_data_n_out,
   output logic bus_data_n_oe,
   input wire logic [`GROUPS-1:0] positive_beat_strobe_n_in,
   output logic [`GROUPS-1:0] positive_beat_strobe_n_out,
   output logic [`GROUPS-1:0] positive_beat_strobe_n_oe,
   input wire logic [`GROUPS-1:0] negative_beat_strobe_n_in,
   output logic [`GROUPS-1:0] negative_beat_strobe_n_out,
   output logic [`GROUPS-1:0] negative_beat_strobe_n_oe
);
   // Picks one beat of a line, beat zero in the low word.
   function automatic logic [`DATA_W-1:0] beat_slice(
      input logic [`LINE_W-1:0] line,
      input logic [`BEAT_W-1:0] idx
   );
      beat_slice = line[int'(idx) * `DATA_W +: `DATA_W];
   endfunction

   // Tells whether a strap value is one of the defined frequency codes.
   function automatic logic freq_code_ok(input logic [`FSEL_W-1:0] code);
      freq_code_ok = (code == `FSEL_CODE_A) || (code == `FSEL_CODE_B) ||
                     (code == `FSEL_CODE_C) || (code == `FSEL_CODE_D);
   endfunction

   // ------------------------------------------------------------------------
   // Core clock side: frequency select, transmit FIFO and handshakes
   // ------------------------------------------------------------------------
   logic [`FSEL_W-1:0] strap_s1_q;
   logic [`FSEL_W-1:0] strap_s2_q;
   logic [1:0] sel_wait_q;
   logic sel_done_q;
   logic fifo_valid;
   logic fifo_pop;
   logic [`LINE_W-1:0] fifo_data;
   logic [`LINE_W-1:0] tx_line_q;
   logic tx_busy_q;
   logic req_tog_q;
   logic ack_tog_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic ack_s3_q;
   logic rx_tog_s1_q;
   logic rx_tog_s2_q;
   logic rx_tog_s3_q;
   logic [`LINE_W-1:0] rx_hold_q;
   logic rx_tog_q;
   // The strap pins pass two flops, then the code is caught once after reset.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         strap_s1_q <= `FSEL_DEFAULT;
         strap_s2_q <= `FSEL_DEFAULT;
         sel_wait_q <= 2'h0;
         sel_done_q <= 1'b0;
         bus_frequency_select <= `FSEL_DEFAULT;
      end else begin
         strap_s1_q <= freq_strap;
         strap_s2_q <= strap_s1_q;
         if (!sel_done_q) begin
            sel_wait_q <= sel_wait_q + 1'b1;
            if (sel_wait_q == `RST_HOLD) begin
               sel_done_q <= 1'b1;
               // Undefined strap codes fall back to the default code.
               bus_frequency_select <= freq_code_ok(strap_s2_q) ?
                                       strap_s2_q : `FSEL_DEFAULT;
            end
         end
      end
   end

   // Lines queue here; a full queue stalls the source through tx_ready.
   line_fifo #(
      .WIDTH(`LINE_W),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rstn(rstn),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   assign fifo_pop = fifo_valid & ~tx_busy_q;

   // One line at a time is held steady and offered to the link by a toggle.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_line_q <= '0;
         tx_busy_q <= 1'b0;
         req_tog_q <= 1'b0;
      end else if (fifo_pop) begin
         tx_line_q <= fifo_data;
         tx_busy_q <= 1'b1;
         req_tog_q <= ~req_tog_q;
      end else if (ack_s3_q != ack_s2_q) begin
         tx_busy_q <= 1'b0;
      end
   end

   // Acknowledge and receive toggles from the link are synchronised here.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
         rx_tog_s1_q <= 1'b0;
         rx_tog_s2_q <= 1'b0;
         rx_tog_s3_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_tog_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         rx_tog_s1_q <= rx_tog_q;
         rx_tog_s2_q <= rx_tog_s1_q;
         rx_tog_s3_q <= rx_tog_s2_q;
      end
   end

   // A received line is copied out with a one-cycle valid pulse.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_valid <= 1'b0;
         rx_data <= '0;
      end else begin
         rx_valid <= rx_tog_s3_q != rx_tog_s2_q;
         if (rx_tog_s3_q != rx_tog_s2_q) begin
            rx_data <= rx_hold_q;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Bus clock side: reset, pin synchronisers, transmit state machine
   // ------------------------------------------------------------------------
   logic [1:0] link_rst_q;
   logic link_rst_n;
   logic req_s1_q;
   logic req_s2_q;
   logic prio_s1_q;
   logic prio_s2_q;
   logic valid_s1_q;
   logic valid_s2_q;
   logic [`DATA_W-1:0] dat_s1_q;
   logic [`DATA_W-1:0] dat_s2_q;
   logic [`GROUPS-1:0] pos_s1_q;
   logic [`GROUPS-1:0] pos_s2_q;
   logic [`GROUPS-1:0] pos_s3_q;
   logic [`GROUPS-1:0] neg_s1_q;
   logic [`GROUPS-1:0] neg_s2_q;
   logic [`GROUPS-1:0] neg_s3_q;
   tx_state_t tx_state_q;
   logic [`BEAT_W-1:0] beat_q;
   logic [`BEAT_W-1:0] out_beat_q;
   logic [2:0] drv_hist_q;

   // The bus clock domain leaves reset only after two of its own edges.
   always_ff @(posedge beat_clk or negedge rstn) begin
      if (!rstn) begin
         link_rst_q <= 2'h0;
      end else begin
         link_rst_q <= {link_rst_q[0], 1'b1};
      end
   end
   assign link_rst_n = link_rst_q[1];

   // Pins and the request toggle pass two flops; strobes keep a third for edges.
   always_ff @(posedge beat_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         prio_s1_q <= 1'b1;
         prio_s2_q <= 1'b1;
         valid_s1_q <= 1'b1;
         valid_s2_q <= 1'b1;
         dat_s1_q <= '1;
         dat_s2_q <= '1;
         pos_s1_q <= '1;
         pos_s2_q <= '1;
         pos_s3_q <= '1;
         neg_s1_q <= '1;
         neg_s2_q <= '1;
         neg_s3_q <= '1;
      end else begin
         req_s1_q <= req_tog_q;
         req_s2_q <= req_s1_q;
         prio_s1_q <= priority_agent_request_n;
         prio_s2_q <= prio_s1_q;
         valid_s1_q <= transfer_valid_indicator_n_in;
         valid_s2_q <= valid_s1_q;
         dat_s1_q <= bus_data_n_in;
         dat_s2_q <= dat_s1_q;
         pos_s1_q <= positive_beat_strobe_n_in;
         pos_s2_q <= pos_s1_q;
         pos_s3_q <= pos_s2_q;
         neg_s1_q <= negative_beat_strobe_n_in;
         neg_s2_q <= neg_s1_q;
         neg_s3_q <= neg_s2_q;
      end
   end

   // Request, wait for ownership, drive four beats, then acknowledge.
   always_ff @(posedge beat_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_state_q <= tx_idle;
         beat_q <= '0;
         ack_tog_q <= 1'b0;
      end else begin
         case (tx_state_q)
            tx_idle: begin
               if (req_s2_q != ack_tog_q) begin
                  tx_state_q <= tx_req;
               end
            end
            tx_req: begin
               // Wait while the priority agent requests or another agent's transfer is valid.
               if (prio_s2_q && valid_s2_q) begin
                  tx_state_q <= tx_drive;
                  beat_q <= '0;
               end
            end
            tx_drive: begin
               beat_q <= beat_q + 1'b1;
               if (beat_q == `LAST_BEAT) begin
                  tx_state_q <= tx_done;
               end
            end
            tx_done: begin
               ack_tog_q <= ~ack_tog_q;
               tx_state_q <= tx_idle;
            end
            default: begin
               tx_state_q <= tx_idle;
            end
         endcase
      end
   end

   // Pin drivers all come from flops clocked by the one bus clock.
   always_ff @(posedge beat_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bus_ownership_request_n_out <= 1'b1;
         bus_ownership_request_n_oe <= 1'b0;
         transfer_valid_indicator_n_out <= 1'b1;
         transfer_valid_indicator_n_oe <= 1'b0;
         bus_data_n_out <= '1;
         bus_data_n_oe <= 1'b0;
         positive_beat_strobe_n_out <= '1;
         positive_beat_strobe_n_oe <= '0;
         negative_beat_strobe_n_out <= '1;
         negative_beat_strobe_n_oe <= '0;
         out_beat_q <= '0;
      end else begin
         bus_ownership_request_n_oe <= 1'b1;
         bus_ownership_request_n_out <= tx_state_q == tx_idle;
         if (tx_state_q == tx_drive) begin
            transfer_valid_indicator_n_out <= 1'b0;
            bus_data_n_out <= ~beat_slice(tx_line_q, beat_q);
            // Positive strobes fall on even beats, negative ones on odd beats.
            positive_beat_strobe_n_out <= {`GROUPS{beat_q[0]}};
            negative_beat_strobe_n_out <= {`GROUPS{~beat_q[0]}};
            out_beat_q <= beat_q;
         end else begin
            transfer_valid_indicator_n_out <= 1'b1;
            bus_data_n_out <= '1;
            positive_beat_strobe_n_out <= '1;
            negative_beat_strobe_n_out <= '1;
         end
         transfer_valid_indicator_n_oe <= tx_state_q == tx_drive;
         bus_data_n_oe <= tx_state_q == tx_drive;
         positive_beat_strobe_n_oe <= {`GROUPS{tx_state_q == tx_drive}};
         negative_beat_strobe_n_oe <= {`GROUPS{tx_state_q == tx_drive}};
      end
   end

   // ------------------------------------------------------------------------
   // Bus clock side: receive capture per strobe group
   // ------------------------------------------------------------------------
   logic rx_listen;
   logic rx_all;
   logic [`GROUPS-1:0] rx_done;
   logic [`LINE_W-1:0] rx_line;

   // Own beats echo back through the synchronisers, so they are masked.
   always_ff @(posedge beat_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         drv_hist_q <= 3'h0;
      end else begin
         drv_hist_q <= {drv_hist_q[1:0], bus_data_n_oe};
      end
   end
   assign rx_listen = ~|drv_hist_q & ~bus_data_n_oe & ~valid_s2_q;
   assign rx_all = &rx_done;

   for (genvar g = 0; g < `GROUPS; g++) begin : grp
      logic [`BEAT_W-1:0] cnt_q;
      logic done_q;
      logic [`BEATS*`GROUP_W-1:0] grp_q;
      logic fall;

      assign fall = (pos_s3_q[g] & ~pos_s2_q[g]) | (neg_s3_q[g] & ~neg_s2_q[g]);
      assign rx_done[g] = done_q;

      // Each strobe fall latches this group's sixteen lines as one beat.
      always_ff @(posedge beat_clk or negedge link_rst_n) begin
         if (!link_rst_n) begin
            cnt_q <= '0;
            done_q <= 1'b0;
            grp_q <= '0;
         end else begin
            if (rx_all) begin
               done_q <= 1'b0;
            end
            if (fall && rx_listen) begin
               grp_q[int'(cnt_q) * `GROUP_W +: `GROUP_W] <=
                  ~dat_s2_q[g * `GROUP_W +: `GROUP_W];
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == `LAST_BEAT) begin
                  done_q <= 1'b1;
               end
            end
         end
      end

      for (genvar b = 0; b < `BEATS; b++) begin : bt
         assign rx_line[b * `DATA_W + g * `GROUP_W +: `GROUP_W] =
            grp_q[b * `GROUP_W +: `GROUP_W];
      end
   end

   // A full line is snapshotted and announced to the core by a toggle.
   always_ff @(posedge beat_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_hold_q <= '0;
         rx_tog_q <= 1'b0;
      end else if (rx_all) begin
         rx_hold_q <= rx_line;
         rx_tog_q <= ~rx_tog_q;
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   a_request_while_drive:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      tx_state_q == tx_drive |-> !bus_ownership_request_n_out)
      else $error("bus request not asserted while driving");

   a_owner_no_priority:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      $rose(bus_data_n_oe) |-> $past(prio_s2_q, 2))
      else $error("data driven while priority agent requested");

   a_select_code_held:
   assert property (@(posedge mclk) disable iff (!rstn)
      sel_done_q |-> freq_code_ok(bus_frequency_select) ##1 $stable(bus_frequency_select))
      else $error("frequency select invalid or changed");

   a_beat_data_slice:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      bus_data_n_oe |-> bus_data_n_out == ~beat_slice(tx_line_q, out_beat_q))
      else $error("driven beat does not match line slice");

   a_valid_with_data:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      bus_data_n_oe |-> transfer_valid_indicator_n_oe && !transfer_valid_indicator_n_out)
      else $error("data driven without transfer valid");

   a_drive_four_beats:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      $rose(bus_data_n_oe) |-> bus_data_n_oe[*4] ##1 !bus_data_n_oe)
      else $error("drive window is not four beats");

   a_strobes_alternate:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      bus_data_n_oe && $past(bus_data_n_oe) |->
      positive_beat_strobe_n_out[0] != $past(positive_beat_strobe_n_out[0]) &&
      negative_beat_strobe_n_out[0] != $past(negative_beat_strobe_n_out[0]))
      else $error("strobes did not alternate per beat");

   a_groups_in_step:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      positive_beat_strobe_n_out == {`GROUPS{positive_beat_strobe_n_out[0]}} &&
      negative_beat_strobe_n_out == {`GROUPS{negative_beat_strobe_n_out[0]}})
      else $error("strobe groups out of step");

   a_rx_line_complete:
   assert property (@(posedge beat_clk) disable iff (!link_rst_n)
      $changed(rx_tog_q) |-> $past(rx_done) == '1)
      else $error("line announced before all groups done");

   c_tx_line: cover property (@(posedge beat_clk) disable iff (!link_rst_n)
      tx_state_q == tx_done);
   c_rx_line: cover property (@(posedge mclk) disable iff (!rstn) rx_valid);
   c_priority_wait: cover property (@(posedge beat_clk) disable iff (!link_rst_n)
      tx_state_q == tx_req && !prio_s2_q);
endmodule // processor_bus_path

// ---- tb/chipset_model.sv ----
// Behavioural chipset: captures device lines from the bus and sends lines back.
`timescale 1ns/1ns
module chipset_model (
   input wire logic beat_clk,
   input wire logic valid_w,
   input wire logic [63:0] data_w,
   input wire logic [3:0] pos_w,
   input wire logic [3:0] neg_w,
   input wire logic dev_oe,
   output logic prio_n,
   output logic c_oe,
   output logic c_valid_n,
   output logic [63:0] c_data_n,
   output logic [3:0] c_pos_n,
   output logic [3:0] c_neg_n,
   output logic [255:0] got_line,
   output int got_count
);
   logic [3:0] pos_q;
   logic [3:0] neg_q;
   logic [1:0] cnt [4];

   // Idle state: nothing driven, every line left to its pull-up.
   initial begin
      prio_n = 1'h1;
      c_oe = 1'h0;
      c_valid_n = 1'h1;
      c_data_n = '1;
      c_pos_n = 4'hf;
      c_neg_n = 4'hf;
      got_line = '0;
      got_count = 0;
      pos_q = 4'hf;
      neg_q = 4'hf;
      for (int n = 0; n < 4; n++) cnt[n] = 2'h0;
   end

   // Each strobe fall in a group latches that group's 16 lines as the next beat.
   always @(negedge beat_clk) begin
      for (int n = 0; n < 4; n++) begin
         if (!valid_w && !c_oe && ((pos_q[n] && !pos_w[n]) || (neg_q[n] && !neg_w[n]))) begin
            got_line[64 * cnt[n] + 16 * n +: 16] = ~data_w[16 * n +: 16];
            if (n == 3 && cnt[n] == 2'h3) got_count++;
            cnt[n] = cnt[n] + 2'h1;
         end
      end
      pos_q = pos_w;
      neg_q = neg_w;
   end

   // Raises or drops the priority request alone, without sending any data.
   task automatic hold_priority(input logic req_n);
      prio_n = req_n;
   endtask

   // Claims the bus as priority agent, waits for the device to let go, drives 4 beats.
   task automatic send_line(input logic [255:0] line);
      prio_n = 1'h0;
      repeat (4) @(negedge beat_clk);
      while (dev_oe) @(negedge beat_clk);
      for (int k = 0; k < 4; k++) begin
         c_oe = 1'h1;
         c_valid_n = 1'h0;
         c_data_n = ~line[64 * k +: 64];
         c_pos_n = {4{k[0]}};
         c_neg_n = {4{~k[0]}};
         @(negedge beat_clk);
      end
      c_oe = 1'h0;
      c_valid_n = 1'h1;
      prio_n = 1'h1;
   endtask
endmodule // chipset_model

// ---- tb/processor_bus_path_test.sv ----
// Self-checking bench for the processor bus path against the chipset model.
`timescale 1ns/1ns
module processor_bus_path_test;
   import bus_path_pkg::*;
   logic mclk, rstn, beat_clk, tx_valid, tx_ready, rx_valid;
   logic [2:0] freq_strap, fsel;
   logic [255:0] tx_data, rx_data;
   logic req_out, req_oe, vo, voe, doe, prio_n, c_oe, c_v, req_w, valid_w;
   logic [63:0] dout, c_d, data_w;
   logic [3:0] po, poe, no, noe, c_p, c_n, pos_w, neg_w;
   logic [255:0] got_line;
   int got_count, failures, comparisons, cycles;

   // Wire levels: whoever enables drives, otherwise the pull-up wins.
   assign req_w = req_oe ? req_out : 1'h1;
   assign valid_w = voe ? vo : (c_oe ? c_v : 1'h1);
   assign data_w = doe ? dout : (c_oe ? c_d : '1);
   assign pos_w = (poe & po) | (~poe & (c_oe ? c_p : 4'hf));
   assign neg_w = (noe & no) | (~noe & (c_oe ? c_n : 4'hf));

   processor_bus_path uut (.mclk(mclk), .rstn(rstn), .beat_clk(beat_clk),
      .freq_strap(freq_strap), .bus_frequency_select(fsel), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
      .bus_ownership_request_n_in(req_w), .bus_ownership_request_n_out(req_out),
      .bus_ownership_request_n_oe(req_oe), .priority_agent_request_n(prio_n),
      .transfer_valid_indicator_n_in(valid_w), .transfer_valid_indicator_n_out(vo),
      .transfer_valid_indicator_n_oe(voe), .bus_data_n_in(data_w), .bus_data_n_out(dout),
      .bus_data_n_oe(doe), .positive_beat_strobe_n_in(pos_w),
      .positive_beat_strobe_n_out(po), .positive_beat_strobe_n_oe(poe),
      .negative_beat_strobe_n_in(neg_w), .negative_beat_strobe_n_out(no),
      .negative_beat_strobe_n_oe(noe));

   chipset_model chip (.beat_clk(beat_clk), .valid_w(valid_w), .data_w(data_w),
      .pos_w(pos_w), .neg_w(neg_w), .dev_oe(doe), .prio_n(prio_n), .c_oe(c_oe),
      .c_valid_n(c_v), .c_data_n(c_d), .c_pos_n(c_p), .c_neg_n(c_n),
      .got_line(got_line), .got_count(got_count));

   // ---------------------------------------------------------------------
   // Clocks, timeout and helpers
   // ---------------------------------------------------------------------
   // Core clock at 10 MHz; link clock at 160 ns with an odd phase offset.
   always #50 mclk = ~mclk;
   initial begin
      beat_clk = 1'h0;
      #37;
      forever #80 beat_clk = ~beat_clk;
   end

   // A hung scenario is cut short and counted as a mismatch.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

   task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Every 16-bit slice differs, so a swapped beat or group shows up.
   function automatic logic [255:0] mk(input int i);
      for (int b = 0; b < 16; b++) mk[16 * b +: 16] = 16'(i * 256 + b + 1);
   endfunction

   task automatic do_reset(input logic [2:0] strap, input logic [2:0] exp);
      @(negedge mclk);
      rstn = 1'h0;
      freq_strap = strap;
      repeat (5) @(negedge mclk);
      check("reset outputs", {req_oe, voe, doe, tx_ready, rx_valid, poe, noe}, '0);
      rstn = 1'h1;
      repeat (6) @(negedge mclk);
      check("frequency select", fsel, exp);
   endtask

   // Offers a line and leaves tx_valid high; it is taken at the first rising edge with tx_ready high.
   task automatic send_tx(input logic [255:0] line);
      tx_data = line;
      tx_valid = 1'h1;
      while (tx_ready !== 1'h1) @(negedge mclk);
      @(negedge mclk);
   endtask

   task automatic wait_got(input int n, input logic [255:0] exp);
      for (int i = 0; i < 400 && got_count != n; i++) @(negedge mclk);
      check("line on bus", got_line, exp);
   endtask

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_select();
      do_reset(3'h2, 3'h2);
      do_reset(3'h5, 3'h0);
      do_reset(3'h1, 3'h1);
   endtask

   task automatic t_tx_one();
      send_tx(mk(1));
      tx_valid = 1'h0;
      for (int i = 0; i < 100 && req_w !== 1'h0; i++) @(negedge mclk);
      check("request asserted", req_w, 1'h0);
      wait_got(1, mk(1));
      repeat (20) @(negedge mclk);
      check("request released", {req_w, doe}, 2'h2);
   endtask

   // Priority agent holds the bus while the FIFO fills up and refuses.
   task automatic t_prio_fill();
      chip.hold_priority(1'h0);
      for (int i = 2; i < 7; i++) send_tx(mk(i));
      tx_data = mk(7);
      repeat (20) @(negedge mclk);
      check("fifo full", tx_ready, 1'h0);
      check("held off bus", {req_w, doe, voe}, 3'h0);
      chip.hold_priority(1'h1);
      send_tx(mk(7));
      tx_valid = 1'h0;
      for (int i = 2; i < 8; i++) wait_got(i, mk(i));
   endtask

   // The chipset sends a line; it must come out as one rx_valid pulse.
   task automatic t_rx();
      fork
         chip.send_line(mk(9));
         begin
            for (int i = 0; i < 200 && rx_valid !== 1'h1; i++) @(negedge mclk);
            check("rx data", rx_data, mk(9));
            @(negedge mclk);
            check("rx pulse", rx_valid, 1'h0);
         end
      join
   endtask

   task automatic final_report();
      if (failures == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Main sequence, inputs set at time zero and changed at falling core edges.
   initial begin
      mclk = 1'h0;
      rstn = 1'h0;
      freq_strap = 3'h0;
      tx_valid = 1'h0;
      tx_data = '0;
      failures = 0;
      comparisons = 0;
      cycles = 0;
      t_select();
      t_tx_one();
      t_prio_fill();
      t_rx();
      final_report();
   end
endmodule // processor_bus_path_test
